// [logic/tplic_ctrl.sv]
// Purpose : Two-level priority interrupt controller with APB register access
// Assumes : Core acknowledges a taken request and signals the return instruction
// Notes   : APB answers one wait state after setup; registers sit in the low byte, the Timer0 count in the low half-word
//
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/100ps

module tplic_ctrl import tplic_pkg::*; (
  input  wire logic                       I_CLK,
  input  wire logic                       I_RESET,
  input  wire logic                       I_PSEL,
  input  wire logic                       I_PENABLE,
  input  wire logic                       I_PWRITE,
  input  wire logic [ADDR_W-1:0]          I_PADDR,
  input  wire logic [31:0]                I_PWDATA,
  input  wire logic [NUM_EXT-1:0]         I_EXT_PIN,
  input  wire logic                       I_IOC_FLAG,
  input  wire logic [NUM_GRP*8-9:0]       I_PERIPH_EVENT,
  input  wire logic                       I_IRQ_ACK,
  input  wire logic                       I_RETURN,
  output logic                            O_PREADY,
  output logic                            O_PSLVERR,
  output logic      [31:0]                O_PRDATA,
  output logic                            O_IRQ_HIGH,
  output logic                            O_IRQ_LOW,
  output logic      [15:0]                O_VECTOR,
  output logic                            O_WAKE
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // True when idx falls in the eight-register group starting at base
  function automatic logic in_grp(input logic [IDX_W-1:0] idx, input logic [IDX_W-1:0] base);
    logic [IDX_W-1:0] off;
    off = idx - base;
    in_grp = (idx >= base) && (off < IDX_W'(NUM_GRP));
  endfunction

  // Register number within a group
  function automatic logic [2:0] grp_num(input logic [IDX_W-1:0] idx,
                                         input logic [IDX_W-1:0] base);
    logic [IDX_W-1:0] off;
    off = idx - base;
    grp_num = off[2:0];
  endfunction

  // ****************************************************************
  // Declarations
  // ****************************************************************
  tplic_ctrl_s         ctrl_q;
  logic [7:0][7:0]     flag_q;
  logic [7:0][7:0]     en_q;
  logic [7:0][7:0]     pri_q;
  logic [15:0]         t0_count_q;
  logic [1:0]          t0_ctrl_q;
  tplic_svc_e          svc_q;
  tplic_req_s          req;
  logic                wr_go;
  logic                rd_prep;
  logic                pready_q;
  logic                pslverr_q;
  logic [31:0]         prdata_q;
  logic [7:0]          rd_byte;
  logic                rd_hit;
  logic [NUM_EXT-1:0]  ext_edge;
  logic                t0_wrap;
  logic [7:0][7:0]     set_vec;
  logic [7:0][7:0]     live;
  logic [7:0][7:0]     live_hi;
  logic [7:0][7:0]     live_lo;
  logic                any_core;
  logic                any_periph;
  logic                req_high;
  logic                req_low;
  logic                take_high;
  logic                take_low;
  logic                irq_high_q;
  logic                irq_low_q;
  logic [15:0]         vector_q;
  logic                wake_q;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Request view of the bus
  always_comb begin
    req.idx   = I_PADDR[ADDR_W-1:2];
    req.write = I_PWRITE;
    req.wdata = I_PWDATA[7:0];
  end

  // Write lands only at the completing edge; read data is prepared the cycle before
  assign rd_prep = I_PSEL && I_PENABLE && !pready_q;
  assign wr_go   = I_PSEL && I_PENABLE && pready_q && req.write;

  // Read decode; unmapped words answer with an error and zero data
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    if (in_grp(req.idx, IDX_PRI_BASE)) begin
      rd_byte = pri_q[grp_num(req.idx, IDX_PRI_BASE)];
    end else if (in_grp(req.idx, IDX_EN_BASE)) begin
      rd_byte = en_q[grp_num(req.idx, IDX_EN_BASE)];
    end else if (in_grp(req.idx, IDX_FLAG_BASE)) begin
      rd_byte = flag_q[grp_num(req.idx, IDX_FLAG_BASE)];
    end else if (req.idx == IDX_CTRL) begin
      rd_byte = {ctrl_q.gieh, ctrl_q.giel, ctrl_q.priority_levels_on, 2'h0, ctrl_q.edge_sel};
    end else if (req.idx == IDX_T0_CTRL) begin
      rd_byte = {6'h00, t0_ctrl_q};
    end else if (req.idx == IDX_T0_COUNT) begin
      rd_byte = 8'h00;
    end else begin
      rd_hit = 1'b0;
    end
  end

  // One wait state: pready rises the cycle after the access phase begins
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= RDATA_ZERO;
    end else begin
      pready_q  <= rd_prep;
      pslverr_q <= rd_prep && !rd_hit;
      if (rd_prep && !req.write && req.idx == IDX_T0_COUNT) begin
        prdata_q <= {16'h0000, t0_count_q};
      end else if (rd_prep && !req.write) begin
        prdata_q <= {24'h000000, rd_byte};
      end else begin
        prdata_q <= RDATA_ZERO;
      end
    end
  end

  // ****************************************************************
  // Event sources
  // ****************************************************************
  tplic_edge_det #(
    .W          (NUM_EXT)
  ) u_edge (
    .i_clk      (I_CLK),
    .i_reset    (I_RESET),
    .i_pin      (I_EXT_PIN),
    .i_rise_sel (ctrl_q.edge_sel),
    .o_edge     (ext_edge)
  );

  // Timer0 wraps at FFh in 8-bit mode or FFFFh in 16-bit mode
  assign t0_wrap = t0_ctrl_q[T0_EN_BIT] && (t0_ctrl_q[T0_MODE16_BIT] ?
                   (t0_count_q == T0_MAX16) : (t0_count_q[7:0] == T0_MAX8));

  // Timer0 counter; 8-bit mode keeps the upper byte at zero
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      t0_count_q <= T0_COUNT_RST;
      t0_ctrl_q  <= T0_CTRL_RST;
    end else begin
      if (wr_go && req.idx == IDX_T0_CTRL) begin
        t0_ctrl_q <= req.wdata[1:0];
      end
      if (wr_go && req.idx == IDX_T0_COUNT) begin
        t0_count_q <= I_PWDATA[15:0];
      end else if (t0_ctrl_q[T0_EN_BIT] && t0_wrap) begin
        t0_count_q <= T0_COUNT_RST;
      end else if (t0_ctrl_q[T0_EN_BIT]) begin
        t0_count_q <= t0_ctrl_q[T0_MODE16_BIT] ? (t0_count_q + T0_STEP)
                      : {8'h00, t0_count_q[7:0] + T0_STEP[7:0]};
      end
    end
  end

  // Hardware set vector per flag bit
  always_comb begin
    set_vec                   = {I_PERIPH_EVENT, 8'h00};
    set_vec[0][NUM_EXT-1:0]   = ext_edge;
    set_vec[0][GRP0_T0_BIT]   = t0_wrap;
  end

  // ****************************************************************
  // Flag, enable and priority registers
  // ****************************************************************
  // Set beats a same-cycle software clear; flags ignore every enable
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      flag_q <= {NUM_GRP{FLAG_RST}};
    end else begin
      for (int g = 0; g < NUM_GRP; g++) begin
        if (wr_go && in_grp(req.idx, IDX_FLAG_BASE) &&
            grp_num(req.idx, IDX_FLAG_BASE) == 3'(g)) begin
          flag_q[g] <= req.wdata | set_vec[g];
        end else begin
          flag_q[g] <= flag_q[g] | set_vec[g];
        end
      end
      // Change flag mirrors its source and cannot be written
      flag_q[0][GRP0_IOC_BIT] <= I_IOC_FLAG;
      flag_q[0][7:6]          <= 2'h0;
      flag_q[0][3]            <= 1'b0;
      if (wr_go && req.idx == IDX_FLAG_BASE) begin
        flag_q[0][NUM_EXT-1:0] <= (req.wdata[NUM_EXT-1:0] & GRP0_SW_MASK[NUM_EXT-1:0])
                                  | ext_edge;
        flag_q[0][GRP0_T0_BIT] <= req.wdata[GRP0_T0_BIT] | t0_wrap;
      end
    end
  end

  // Enable and priority banks, one byte per register
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      en_q  <= {NUM_GRP{EN_RST}};
      pri_q <= {NUM_GRP{PRI_RST}};
    end else if (wr_go) begin
      if (in_grp(req.idx, IDX_EN_BASE)) begin
        en_q[grp_num(req.idx, IDX_EN_BASE)] <= req.wdata;
      end
      if (in_grp(req.idx, IDX_PRI_BASE)) begin
        pri_q[grp_num(req.idx, IDX_PRI_BASE)] <= req.wdata;
      end
    end
  end

  // ****************************************************************
  // Gating and request selection
  // ****************************************************************
  // Live sources split by priority; group 0 holds the core sources
  always_comb begin
    for (int g = 0; g < NUM_GRP; g++) begin
      live[g]    = flag_q[g] & en_q[g];
      live_hi[g] = live[g] & pri_q[g];
      live_lo[g] = live[g] & ~pri_q[g];
    end
    live[0]    = live[0] & GRP0_MASK;
    live_hi[0] = live_hi[0] & GRP0_MASK;
    live_lo[0] = live_lo[0] & GRP0_MASK;
    any_core   = |live[0];
    any_periph = |live[NUM_GRP-1:1];
  end

  // Compat mode ignores priority bits and uses one level
  always_comb begin
    if (ctrl_q.priority_levels_on) begin
      req_high = ctrl_q.gieh && (|live_hi);
      req_low  = ctrl_q.gieh && ctrl_q.giel && (|live_lo)
                 && svc_q != ST_SVC_HIGH && svc_q != ST_SVC_BOTH;
    end else begin
      req_high = ctrl_q.gieh && (any_core || (ctrl_q.giel && any_periph));
      req_low  = 1'b0;
    end
  end

  // High always wins the acknowledge, even over a low already raised
  assign take_high = I_IRQ_ACK && irq_high_q;
  assign take_low  = I_IRQ_ACK && !irq_high_q && irq_low_q;

  // Level requests and the vector, all registered
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      irq_high_q <= 1'b0;
      irq_low_q  <= 1'b0;
      vector_q   <= VEC_HIGH;
      wake_q     <= 1'b0;
    end else begin
      irq_high_q <= req_high && !take_high;
      irq_low_q  <= req_low && !take_low && !req_high;
      if (req_high) begin
        vector_q <= VEC_HIGH;
      end else if (req_low) begin
        vector_q <= VEC_LOW;
      end
      // Wake needs only the source enable; branching still needs the global one
      wake_q <= |(flag_q[0][NUM_EXT-1:0] & en_q[0][NUM_EXT-1:0]);
    end
  end

  // ****************************************************************
  // Control register and service tracking
  // ****************************************************************
  // Hardware clears the serviced enable on response and restores it on return;
  // a software write in the same cycle loses to the hardware action.
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      ctrl_q.gieh     <= 1'b0;
      ctrl_q.giel     <= 1'b0;
      ctrl_q.priority_levels_on     <= 1'b0;
      ctrl_q.edge_sel <= EDGE_RST;
    end else begin
      if (wr_go && req.idx == IDX_CTRL) begin
        ctrl_q.gieh     <= req.wdata[CTRL_GIEH_BIT];
        ctrl_q.giel     <= req.wdata[CTRL_GIEL_BIT];
        ctrl_q.priority_levels_on     <= req.wdata[CTRL_PRIORITY_LEVELS_ON_BIT];
        ctrl_q.edge_sel <= req.wdata[NUM_EXT-1:0];
      end
      if (take_high) begin
        ctrl_q.gieh <= 1'b0;
      end else if (take_low) begin
        ctrl_q.giel <= 1'b0;
      end else if (I_RETURN) begin
        if (ctrl_q.priority_levels_on && (svc_q == ST_SVC_LOW)) begin
          ctrl_q.giel <= 1'b1;
        end else begin
          ctrl_q.gieh <= 1'b1;
        end
      end
    end
  end

  // Service nesting: low, high, or high on top of low
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      svc_q <= ST_IDLE;
    end else begin
      case (svc_q)
        ST_IDLE: begin
          if (take_high) begin
            svc_q <= ST_SVC_HIGH;
          end else if (take_low) begin
            svc_q <= ST_SVC_LOW;
          end
        end
        ST_SVC_LOW: begin
          if (take_high) begin
            svc_q <= ST_SVC_BOTH;
          end else if (I_RETURN) begin
            svc_q <= ST_IDLE;
          end
        end
        ST_SVC_HIGH: begin
          if (I_RETURN) begin
            svc_q <= ST_IDLE;
          end
        end
        ST_SVC_BOTH: begin
          if (I_RETURN) begin
            svc_q <= ST_SVC_LOW;
          end
        end
        default: begin
          svc_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  // Fixed pipeline from pin to request keeps latency instruction independent
  assign O_PREADY   = pready_q;
  assign O_PSLVERR  = pslverr_q;
  assign O_PRDATA   = prdata_q;
  assign O_IRQ_HIGH = irq_high_q;
  assign O_IRQ_LOW  = irq_low_q;
  assign O_VECTOR   = vector_q;
  assign O_WAKE     = wake_q;

endmodule // tplic_ctrl

// [logic/tplic_pkg.sv]
// Purpose : Shared constants and types of the two-level interrupt controller
// Assumes : APB data is 32 bits, registers are 8 bits wide in the low lane except the 16-bit Timer0 count
// Notes   : Register indices are word indices, byte address = index * 4
package tplic_pkg;

  // ****************************************************************
  // Register indices and bus widths
  // ****************************************************************
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned IDX_W  = 14;
  localparam int unsigned NUM_GRP = 8;                // Eight flag, enable, priority regs
  localparam logic [IDX_W-1:0] IDX_PRI_BASE  = 14'h0EBA;
  localparam logic [IDX_W-1:0] IDX_EN_BASE   = 14'h0EC2;
  localparam logic [IDX_W-1:0] IDX_FLAG_BASE = 14'h0ECA;
  localparam logic [IDX_W-1:0] IDX_CTRL      = 14'h0FF2;
  localparam logic [IDX_W-1:0] IDX_T0_CTRL   = 14'h0F00;
  localparam logic [IDX_W-1:0] IDX_T0_COUNT  = 14'h0F01;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int unsigned CTRL_GIEH_BIT = 7;
  localparam int unsigned CTRL_GIEL_BIT = 6;
  localparam int unsigned CTRL_PRIORITY_LEVELS_ON_BIT = 5;
  localparam int unsigned NUM_EXT       = 3;
  localparam int unsigned GRP0_IOC_BIT  = 4;
  localparam int unsigned GRP0_T0_BIT   = 5;
  localparam int unsigned T0_EN_BIT     = 0;
  localparam int unsigned T0_MODE16_BIT = 1;
  localparam logic [7:0]  GRP0_MASK     = 8'h37;      // Implemented bits of group 0
  localparam logic [7:0]  GRP0_SW_MASK  = 8'h27;      // Software-clearable bits of group 0

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [2:0]  EDGE_RST     = 3'h7;        // Rising edge after reset
  localparam logic [7:0]  PRI_RST      = 8'hFF;
  localparam logic [7:0]  EN_RST       = 8'h00;
  localparam logic [7:0]  FLAG_RST     = 8'h00;
  localparam logic [15:0] T0_COUNT_RST = 16'h0000;
  localparam logic [1:0]  T0_CTRL_RST  = 2'h0;

  // ****************************************************************
  // Vectors and timer wrap points
  // ****************************************************************
  localparam logic [15:0] VEC_HIGH   = 16'h0008;
  localparam logic [15:0] VEC_LOW    = 16'h0018;
  localparam logic [7:0]  T0_MAX8    = 8'hFF;
  localparam logic [15:0] T0_MAX16   = 16'hFFFF;
  localparam logic [15:0] T0_STEP    = 16'h0001;
  localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic       gieh;                                  // High or global enable
    logic       giel;                                  // Low or peripheral enable
    logic       priority_levels_on;                                  // Priority levels on
    logic [2:0] edge_sel;                              // 1 = rising, 0 = falling
  } tplic_ctrl_s;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic             write;
    logic [7:0]       wdata;
  } tplic_req_s;

  typedef enum {ST_IDLE, ST_SVC_LOW, ST_SVC_HIGH, ST_SVC_BOTH} tplic_svc_e;

endpackage : tplic_pkg

// [logic/tplic_edge_det.sv]
// Purpose : Synchronise external pins and detect the selected edge
// Assumes : Pins are asynchronous to the core clock
// Notes   : Output is a one-cycle pulse per selected edge
`timescale 1ns/100ps
module tplic_edge_det import tplic_pkg::*; #(
  parameter int unsigned W = 3
) (
  input  wire logic         i_clk,
  input  wire logic         i_reset,
  input  wire logic [W-1:0] i_pin,
  input  wire logic [W-1:0] i_rise_sel,
  output logic      [W-1:0] o_edge
);

  // ****************************************************************
  // Two-stage synchroniser plus history stage
  // ****************************************************************
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  // First stage feeds only the second, so metastability cannot spread.
  // The chain runs through reset, so a pin idling high is no false edge.
  always_ff @(posedge i_clk) begin
    meta_q <= i_pin;
    sync_q <= meta_q;
    prev_q <= sync_q;
  end

  // Pick rising or falling edge per input; nothing is reported in reset
  always_comb begin
    o_edge = '0;
    if (!i_reset) begin
      o_edge = (i_rise_sel & sync_q & ~prev_q) | (~i_rise_sel & ~sync_q & prev_q);
    end
  end

endmodule // tplic_edge_det

// [bench/tplic_monitor.sv]
// Purpose: Port assertions of the interrupt controller
// Assumes: One clock, synchronous active-high reset
// Notes  : Bound to every controller instance
`timescale 1ns/100ps
module tplic_monitor import tplic_pkg::*; (
  input wire logic        I_CLK,
  input wire logic        I_RESET,
  input wire logic        I_PSEL,
  input wire logic        I_PENABLE,
  input wire logic        I_IRQ_ACK,
  input wire logic        O_PREADY,
  input wire logic        O_PSLVERR,
  input wire logic [31:0] O_PRDATA,
  input wire logic        O_IRQ_HIGH,
  input wire logic        O_IRQ_LOW,
  input wire logic [15:0] O_VECTOR
);
  // **********
  // Properties
  // **********
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RESET);
  // Bus answers after exactly one wait state, for one cycle
  a_one_wait: assert property (I_PSEL && !I_PENABLE |=> !O_PREADY ##1 O_PREADY)
    else $error("ready not after one wait state");
  a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
    else $error("ready longer than one cycle");
  a_data_idle: assert property (!O_PREADY |-> O_PRDATA == RDATA_ZERO)
    else $error("read data outside ready");
  a_err_ready: assert property (O_PSLVERR |-> O_PREADY)
    else $error("error without ready");
  // A held request shows the vector of its level
  a_high_vec: assert property (O_IRQ_HIGH && $past(O_IRQ_HIGH) |-> O_VECTOR == VEC_HIGH)
    else $error("high request with wrong vector");
  a_low_vec: assert property (O_IRQ_LOW && $past(O_IRQ_LOW) |-> O_VECTOR == VEC_LOW)
    else $error("low request with wrong vector");
  a_low_yields: assert property ($rose(O_IRQ_LOW) |-> !O_IRQ_HIGH)
    else $error("low raised beside high");
  // Taking a request clears its enable, so the request falls
  a_high_taken: assert property (I_IRQ_ACK && O_IRQ_HIGH |-> ##[1:2] !O_IRQ_HIGH)
    else $error("high request stays after ack");
  a_low_taken: assert property (I_IRQ_ACK && O_IRQ_LOW && !O_IRQ_HIGH |-> ##[1:2] !O_IRQ_LOW)
    else $error("low request stays after ack");
  c_low: cover property (I_IRQ_ACK && O_IRQ_LOW);
  c_high: cover property (I_IRQ_ACK && O_IRQ_HIGH);
  c_refused: cover property (O_PSLVERR);
endmodule // tplic_monitor
bind tplic_ctrl tplic_monitor tplic_monitor_inst (
  .I_CLK(I_CLK), .I_RESET(I_RESET), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_IRQ_ACK(I_IRQ_ACK), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_PRDATA(O_PRDATA),
  .O_IRQ_HIGH(O_IRQ_HIGH), .O_IRQ_LOW(O_IRQ_LOW), .O_VECTOR(O_VECTOR));

// [bench/tplic_core_model.sv]
// Purpose: Core that takes raised requests and returns from service
// Assumes: Requests are levels, ack and return are one-cycle pulses
// Notes  : Waits three cycles or more so a falling request is not taken twice
`timescale 1ns/100ps
module tplic_core_model (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_irq_high,
  input  wire logic        i_irq_low,
  input  wire logic [15:0] i_vector,
  input  wire logic        i_allow,
  input  wire logic        i_slow,
  input  wire logic        i_ret_req,
  output logic             o_ack,
  output logic             o_ret,
  output logic      [15:0] o_vec_q
);
  // ********
  // Response
  // ********
  logic [3:0] wait_q;
  // Prompt or slow answer; the taken vector is kept for the bench
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      wait_q  <= 4'h0;
      o_ack   <= 1'h0;
      o_vec_q <= 16'h0000;
    end else begin
      o_ack <= 1'h0;
      if (!(i_allow && (i_irq_high || i_irq_low))) begin
        wait_q <= 4'h0;
      end else if (wait_q == (i_slow ? 4'h6 : 4'h3)) begin
        o_ack   <= 1'h1;
        o_vec_q <= i_vector;
        wait_q  <= 4'h0;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
  // Return follows the software request by one cycle
  always_ff @(posedge i_clk) begin
    o_ret <= i_ret_req && !i_reset;
  end
endmodule // tplic_core_model

// [bench/tb.sv]
// Purpose: Self-checking bench of the interrupt controller
// Assumes: One wait state on the bus, core model takes requests
// Notes  : Pin events need three cycles to reach a flag
`timescale 1ns/100ps
`define CHK(a, x) begin cmp_count++; if ((a) !== (x)) begin failures++; \
  $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (a), (x)); end end
module tb import tplic_pkg::*;;
  logic        clk = 1'h0, rst = 1'h1, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
  logic        allow = 1'h0, slow = 1'h0, retq = 1'h0, ioc = 1'h0, e;
  logic        prdy, perr, irqh, irql, wake, ack, ret;
  logic [15:0] paddr = 16'h0000, vec, vq;
  logic [31:0] pwdata = 32'h0, prdata, v;
  logic [2:0]  pin = 3'h0;
  logic [55:0] pev = 56'h0;
  int          failures = 0, cmp_count = 0, cyc = 0;
  tplic_ctrl tplic_ctrl_inst (
    .I_CLK(clk), .I_RESET(rst), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .I_EXT_PIN(pin), .I_IOC_FLAG(ioc),
    .I_PERIPH_EVENT(pev), .I_IRQ_ACK(ack), .I_RETURN(ret), .O_PREADY(prdy),
    .O_PSLVERR(perr), .O_PRDATA(prdata), .O_IRQ_HIGH(irqh), .O_IRQ_LOW(irql),
    .O_VECTOR(vec), .O_WAKE(wake));
  tplic_core_model tplic_core_model_inst (
    .i_clk(clk), .i_reset(rst), .i_irq_high(irqh), .i_irq_low(irql), .i_vector(vec),
    .i_allow(allow), .i_slow(slow), .i_ret_req(retq), .o_ack(ack), .o_ret(ret),
    .o_vec_q(vq));
  always #2.5 clk = ~clk;
  // *****************
  // Bus and utilities
  // *****************
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [13:0] idx, input logic [15:0] d);
    psel <= 1'h1;
    pwr <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {16'h0000, d};
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
    end while (prdy !== 1'h1);
    v = prdata;
    e = perr;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [13:0] idx, input logic [15:0] d, input int n);
    apb(1'h1, idx, d);
    tick(n);
  endtask
  task automatic rdchk(input logic [13:0] idx, input logic [7:0] x);
    apb(1'h0, idx, 16'h0000);
    `CHK(v, {24'h000000, x})
  endtask
  task automatic ev(input logic [55:0] p);
    pev <= p;
    tick(1);
    pev <= 56'h0;
    tick(4);
  endtask
  task automatic rti;
    retq <= 1'h1;
    tick(1);
    retq <= 1'h0;
    tick(3);
  endtask
  // *********
  // Scenarios
  // *********
  task automatic t_reset;
    `CHK(vec, VEC_HIGH)
    rdchk(IDX_CTRL, 8'h07);
    rdchk(IDX_PRI_BASE + 14'h7, PRI_RST);
    rdchk(IDX_EN_BASE, EN_RST);
    apb(1'h0, 14'h0ED2, 16'h0000);
    `CHK({e, v}, 33'h100000000)
  endtask
  // Falling select on pin 1 ignores its rise; flags set with all enables off
  task automatic t_edges;
    wr(IDX_CTRL, 16'h0005, 0);
    pin <= 3'h3;
    tick(6);
    rdchk(IDX_FLAG_BASE, 8'h01);
    pin <= 3'h1;
    tick(6);
    rdchk(IDX_FLAG_BASE, 8'h03);
    `CHK({irqh, irql, wake}, 3'h0)
    wr(IDX_EN_BASE, 16'h0002, 3);
    `CHK(wake, 1'h1)
    wr(IDX_FLAG_BASE, 16'h0000, 0);
    wr(IDX_CTRL, 16'h0087, 0);
  endtask
  // Priority bits cleared yet the vector stays high without levels
  task automatic t_compat;
    wr(IDX_PRI_BASE, 16'h0000, 0);
    wr(IDX_EN_BASE, 16'h0001, 0);
    pin <= 3'h0;
    tick(3);
    pin <= 3'h1;
    tick(4);
    `CHK(irqh, 1'h0)
    tick(1);
    `CHK(irqh, 1'h1)
    tick(3);
    `CHK({irqh, irql, vec}, {2'h2, VEC_HIGH})
    allow <= 1'h1;
    tick(8);
    `CHK(vq, VEC_HIGH)
    rdchk(IDX_CTRL, 8'h07);
    wr(IDX_FLAG_BASE, 16'h0000, 0);
    rti();
    rdchk(IDX_CTRL, 8'h87);
    allow <= 1'h0;
    wr(IDX_EN_BASE + 14'h1, 16'h0001, 0);
    ev(56'h1);
    `CHK(irqh, 1'h0)
    wr(IDX_CTRL, 16'h00C7, 3);
    `CHK(irqh, 1'h1)
    wr(IDX_CTRL, 16'h0047, 3);
    `CHK(irqh, 1'h0)
  endtask
  // Low source pending, then a high source preempts its service
  task automatic t_prio;
    wr(IDX_PRI_BASE + 14'h1, 16'h0002, 0);
    wr(IDX_EN_BASE + 14'h1, 16'h0003, 0);
    wr(IDX_CTRL, 16'h0067, 3);
    `CHK(irql, 1'h0)
    wr(IDX_CTRL, 16'h00A7, 3);
    `CHK(irql, 1'h0)
    wr(IDX_CTRL, 16'h00E7, 3);
    `CHK({irqh, irql, vec}, {2'h1, VEC_LOW})
    allow <= 1'h1;
    slow <= 1'h1;
    tick(10);
    rdchk(IDX_CTRL, 8'hA7);
    ev(56'h2);
    tick(10);
    `CHK(vq, VEC_HIGH)
    rdchk(IDX_CTRL, 8'h27);
    wr(IDX_FLAG_BASE + 14'h1, 16'h0001, 0);
    rti();
    rdchk(IDX_CTRL, 8'hA7);
    wr(IDX_FLAG_BASE + 14'h1, 16'h0000, 0);
    rti();
    rdchk(IDX_CTRL, 8'hE7);
    allow <= 1'h0;
    wr(IDX_CTRL, 16'h0007, 0);
  endtask
  task automatic t0_run(input logic [15:0] cnt, input logic [15:0] m, input logic [7:0] x);
    wr(IDX_FLAG_BASE, 16'h0000, 0);
    wr(IDX_T0_COUNT, cnt, 0);
    wr(IDX_T0_CTRL, m, 30);
    wr(IDX_T0_CTRL, 16'h0000, 0);
    rdchk(IDX_FLAG_BASE, x);
  endtask
  // Start and stop of the run
  initial begin
    tick(5);
    rst <= 1'h0;
    tick(1);
    t_reset();
    t_edges();
    t_compat();
    t_prio();
    t0_run(16'h00F0, 16'h0001, 8'h20);
    t0_run(16'h00F0, 16'h0003, 8'h00);
    t0_run(16'hFFF0, 16'h0003, 8'h20);
    wr(IDX_EN_BASE, 16'h0021, 0);
    wr(IDX_CTRL, 16'h0087, 3);
    `CHK(irqh, 1'h1)
    wr(IDX_CTRL, 16'h00E6, 3);
    `CHK({irqh, irql}, 2'h1)
    pin <= 3'h0;
    ioc <= 1'h1;
    tick(6);
    rdchk(IDX_FLAG_BASE, 8'h31);
    wr(IDX_PRI_BASE, 16'h0001, 3);
    `CHK({irqh, irql}, 2'h2)
    summarize();
  end
  // Hang guard, far above the few hundred cycles of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      summarize();
    end
  end
  task automatic summarize;
    $display("Comparisons %0d, failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
endmodule // tb
